// ---- pkg/phy_test_pkg.sv ----
// package: register map, field positions, types and timing for phy test block
`default_nettype none
package phy_test_pkg;
  localparam logic [11:0] off_pattern0      = 12'h210;
  localparam logic [11:0] off_phy_test      = 12'h228;
  localparam logic [11:0] off_serdes_trim   = 12'h22C;
  localparam logic [11:0] off_port_command  = 12'h230;
  localparam logic [11:0] off_selftest_ctrl = 12'h240;
  localparam int          pattern_words     = 4;

  // phy_test_control fields
  localparam int capture_disable_bit   = 3;
  localparam int analog_loopback_bit   = 4;
  localparam int selftest_bit          = 7;
  localparam int prbs_enable_lsb       = 16;
  localparam int prbs_external_lsb     = 20;
  localparam int user_pattern_lsb      = 28;
  localparam logic [31:0] phy_test_writable_mask = 32'h3033_001C;

  // serdes_trim_equalizer fields
  localparam int tx_trim_lsb = 8;
  localparam int rx_trim_lsb = 16;
  localparam int rx_eq_lsb   = 24;
  localparam logic [31:0] serdes_trim_writable_mask = 32'h0FFF_0FFF;

  // port_link_command fields, four bits per port
  localparam int port_count         = 8;
  localparam int loopback_cmd_bit   = 0;
  localparam int scrambler_off_bit  = 1;
  localparam int rx_l1_only_bit     = 2;
  localparam int loopback_ready_bit = 3;
  localparam logic [31:0] port_cmd_writable_mask = 32'h7777_7777;

  localparam logic [31:0] reset_word = 32'h0000_0000;

  // self-test duration
  localparam int clk_mhz          = 100;
  localparam int selftest_time_ms = 16;
  localparam int selftest_cycles  = selftest_time_ms * 1000 * clk_mhz;

  typedef enum logic [1:0]
  {
    loop_none,
    loop_digital_slave,
    loop_analog_slave
  } slave_loop_t;

  typedef enum logic [1:0]
  {
    quad_off,
    quad_internal_analog,
    quad_analog_master
  } quad_loop_t;

  typedef struct packed
  {
    logic [1:0] tx_termination_trim;
    logic [1:0] rx_termination_trim;
    logic [1:0] rx_equalizer_select;
    logic       prbs_run;
    quad_loop_t prbs_loop;
    logic       user_pattern_run;
  } quad_ctrl_t;

  typedef struct packed
  {
    logic [31:0] data;
    logic [3:0]  be;
    logic        write;
  } eeprom_load_t;
endpackage : phy_test_pkg
`default_nettype wire

// ---- rtl/phy_test_regs.sv ----
// phy test and per-port link command register bank with wishbone slave
//
// The Wishbone register port was chosen for this implementation.
`default_nettype none
module phy_test_regs
  import phy_test_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  nrst,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [11:0]           wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic                  eeprom_load_valid,
  input  wire logic [11:0]           eeprom_load_addr,
  input  wire eeprom_load_t          eeprom_load,
  input  wire logic                  eeprom_load_done,
  input  wire logic [port_count-1:0] link_up,
  input  wire logic [port_count-1:0] config_complete,
  input  wire logic [port_count-1:0] loopback_master_state,
  input  wire logic [1:0]            slave_loopback_request,
  output logic                       training_control_capture,
  output slave_loop_t                slave_loop_mode [2],
  output logic                       selftest_running,
  output logic                       link_init_enable,
  output quad_ctrl_t                 quad_ctrl [2],
  output logic      [127:0]          user_pattern,
  output logic [port_count-1:0]      loopback_master_allow,
  output logic [port_count-1:0]      scrambler_disable,
  output logic [port_count-1:0]      rx_l1_only
);

  logic [31:0] phy_test;
  logic [31:0] serdes_trim;
  logic [31:0] port_cmd;
  logic [31:0] pattern [pattern_words];
  logic        selftest_enable;
  logic [port_count-1:0] scr_from_eeprom;
  logic [port_count-1:0] loopback_ready;
  logic [31:0] selftest_count;
  logic        selftest_done;

  function automatic logic [31:0] merge
  (
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0]  be,
    input logic [31:0] mask
  );
    logic [31:0] lane;
    lane = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
    merge = (old & ~lane) | (data & lane);
  endfunction : merge

  // address decode shared by the write and load paths
  function automatic logic reg_hit
  (
    input logic [11:0] addr,
    input logic [11:0] off
  );
    reg_hit = (addr == off);
  endfunction : reg_hit

  // bus write has priority; eeprom load only sees a free cycle
  logic        sw_wr;
  logic        wr_en;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_be;
  logic        from_eeprom;

  assign sw_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;

  always_comb
  begin
    from_eeprom = !sw_wr && eeprom_load_valid && eeprom_load.write;
    wr_en       = sw_wr || from_eeprom;
    wr_addr     = sw_wr ? wb_adr_i : eeprom_load_addr;
    wr_data     = sw_wr ? wb_dat_i : eeprom_load.data;
    wr_be       = sw_wr ? wb_sel_i : eeprom_load.be;
  end

  // one block per register; software and eeprom share one write port
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      phy_test <= reset_word;
    else if (wr_en && reg_hit(wr_addr, off_phy_test))
      phy_test <= merge(phy_test, wr_data, wr_be, phy_test_writable_mask);
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      serdes_trim <= reset_word;
    else if (wr_en && reg_hit(wr_addr, off_serdes_trim))
      serdes_trim <= merge(serdes_trim, wr_data, wr_be,
                           serdes_trim_writable_mask);
  end

  // status bits are masked out here and inserted on the read path
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      port_cmd <= reset_word;
    else if (wr_en && reg_hit(wr_addr, off_port_command))
      port_cmd <= merge(port_cmd, wr_data, wr_be, port_cmd_writable_mask);
  end

  genvar w;
  generate
    for (w = 0; w < pattern_words; w++)
    begin : g_pattern
      always_ff @(posedge sys_clk or negedge nrst)
      begin
        if (!nrst)
          pattern[w] <= reset_word;
        else if (wr_en && wr_addr == off_pattern0 + 12'(4 * w))
          pattern[w] <= merge(pattern[w], wr_data, wr_be, '1);
      end
      assign user_pattern[32*w +: 32] = pattern[w];
    end
  endgenerate

  // self-test enable is only armed by eeprom and never reads back
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      selftest_enable <= 1'b0;
    else if (from_eeprom && wr_addr == off_phy_test && wr_be[0])
      selftest_enable <= wr_data[selftest_bit];
  end

  // 16 ms count starts after the eeprom load finishes
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      selftest_count <= '0;
    else if (!eeprom_load_done || selftest_done || !selftest_enable)
      selftest_count <= '0;
    else
      selftest_count <= selftest_count + 32'd1;
  end

  // without the enable the link may start as soon as the load is done
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      selftest_done <= 1'b0;
    else if (eeprom_load_done && !selftest_done)
    begin
      if (!selftest_enable)
        selftest_done <= 1'b1;
      else if (selftest_count == 32'(selftest_cycles - 1))
        selftest_done <= 1'b1;
    end
  end

  assign selftest_running = eeprom_load_done && selftest_enable
                            && !selftest_done;
  assign link_init_enable = selftest_done;

  // scrambler disable loaded by eeprom waits for configuration complete
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      scr_from_eeprom <= '0;
    else if (from_eeprom && wr_addr == off_port_command)
    begin
      for (int p = 0; p < port_count; p++)
        if (wr_be[p/2])
          scr_from_eeprom[p] <= wr_data[4*p + scrambler_off_bit];
    end
    else if (sw_wr && reg_hit(wb_adr_i, off_port_command))
    begin
      // only lanes software actually wrote lose the eeprom mark
      for (int p = 0; p < port_count; p++)
        if (wb_sel_i[p/2])
          scr_from_eeprom[p] <= 1'b0;
    end
  end

  // ready flag follows the state one cycle later, so leaving clears it
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      loopback_ready <= '0;
    else
      loopback_ready <= loopback_master_state
                        & loopback_master_allow;
  end

  // registered flag masked by the live state, so leaving clears it at once
  logic [port_count-1:0] loopback_status;
  assign loopback_status = loopback_ready & loopback_master_state;

  genvar p;
  generate
    for (p = 0; p < port_count; p++)
    begin : g_port
      logic bit_set;
      logic link_live;
      assign bit_set = port_cmd[4*p + scrambler_off_bit];
      assign link_live = link_up[p] || config_complete[p];
      assign loopback_master_allow[p] =
        port_cmd[4*p + loopback_cmd_bit];
      // eeprom value held until config complete; software value acts at once
      // on a live link, with no retraining
      assign scrambler_disable[p] = bit_set && (scr_from_eeprom[p]
        ? config_complete[p] : link_live);
      assign rx_l1_only[p] = port_cmd[4*p + rx_l1_only_bit];
    end
  endgenerate

  assign training_control_capture = !phy_test[capture_disable_bit];

  // request qualification of the partner's TS1 sets is done upstream
  genvar s;
  generate
    for (s = 0; s < 2; s++)
    begin : g_slave
      always_comb
      begin
        if (!slave_loopback_request[s])
          slave_loop_mode[s] = loop_none;
        else if (phy_test[analog_loopback_bit])
          slave_loop_mode[s] = loop_analog_slave;
        else
          slave_loop_mode[s] = loop_digital_slave;
      end
    end
  endgenerate

  // quad q is associated with the first port of its lanes (port 4*q)
  genvar q;
  generate
    for (q = 0; q < 2; q++)
    begin : g_quad
      logic prbs_on;
      logic ext_sel;
      logic pat_on;
      assign prbs_on = phy_test[prbs_enable_lsb + q];
      assign ext_sel = phy_test[prbs_external_lsb + q];
      assign pat_on  = phy_test[user_pattern_lsb + q];
      always_comb
      begin
        quad_ctrl[q].tx_termination_trim =
          serdes_trim[tx_trim_lsb + 2*q +: 2];
        quad_ctrl[q].rx_termination_trim =
          serdes_trim[rx_trim_lsb + 2*q +: 2];
        quad_ctrl[q].rx_equalizer_select =
          serdes_trim[rx_eq_lsb + 2*q +: 2];
        // pattern wins if software breaks the exclusivity
        quad_ctrl[q].prbs_run = prbs_on && !pat_on;
        if (!prbs_on || !loopback_master_allow[4*q])
          quad_ctrl[q].prbs_loop = quad_off;
        else if (ext_sel)
          quad_ctrl[q].prbs_loop = quad_analog_master;
        else
          quad_ctrl[q].prbs_loop = quad_internal_analog;
        quad_ctrl[q].user_pattern_run = pat_on
          && loopback_ready[4*q];
      end
    end
  endgenerate

  // read path: registered data, one wait-free ack cycle
  logic [31:0] next_rdata;
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    unique case (wb_adr_i)
      off_phy_test:     next_rdata = phy_test;
      off_serdes_trim:  next_rdata = serdes_trim;
      off_port_command:
      begin
        next_rdata = port_cmd;
        for (int i = 0; i < port_count; i++)
          next_rdata[4*i + loopback_ready_bit] =
            loopback_status[i];
      end
      off_pattern0:             next_rdata = pattern[0];
      off_pattern0 + 12'h004:   next_rdata = pattern[1];
      off_pattern0 + 12'h008:   next_rdata = pattern[2];
      off_pattern0 + 12'h00C:   next_rdata = pattern[3];
      off_selftest_ctrl:
        next_rdata = {30'h0000_0000, selftest_done, selftest_running};
      default:          next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= (wb_cyc_i && wb_stb_i && !wb_we_i) ? next_rdata
                                                     : 32'h0000_0000;
    end
  end

endmodule : phy_test_regs
`default_nettype wire

// ---- testbench/phy_test_regs_properties.sv ----
// assertion checker for the phy test register bank
`default_nettype none
module phy_test_regs_properties
  import phy_test_pkg::*;
(
  input wire logic                  sys_clk,
  input wire logic                  nrst,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_we_i,
  input wire logic [11:0]           wb_adr_i,
  input wire logic [3:0]            wb_sel_i,
  input wire logic [31:0]           wb_dat_i,
  input wire logic [31:0]           wb_dat_o,
  input wire logic                  wb_ack_o,
  input wire logic [1:0]            slave_loopback_request,
  input wire logic                  training_control_capture,
  input wire slave_loop_t           slave_loop_mode [2],
  input wire quad_ctrl_t            quad_ctrl [2],
  input wire logic [127:0]          user_pattern,
  input wire logic [port_count-1:0] loopback_master_allow
);
  timeunit 1ns;
  timeprecision 1ps;
  logic req;
  logic wr;
  assign req = wb_cyc_i & wb_stb_i & !wb_ack_o;
  // full-word writes only, so field checks need no lane merge
  assign wr = req & wb_we_i & (wb_sel_i == 4'hF);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  AST_ACK_ONE: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack is not a single pulse");
  AST_CAPTURE: assert property (wr && wb_adr_i == 12'h228
    |=> training_control_capture == !$past(wb_dat_i[3]))
    else $error("capture gate wrong");
  AST_SLAVE_PATH: assert property (wr && wb_adr_i == 12'h228
    ##1 slave_loopback_request[0] |-> slave_loop_mode[0] ==
    ($past(wb_dat_i[4]) ? loop_analog_slave : loop_digital_slave))
    else $error("slave loop path wrong");
  AST_SELFTEST_HIDDEN: assert property (req && !wb_we_i
    && wb_adr_i == 12'h228 |=> !wb_dat_o[7])
    else $error("self-test bit read back");
  AST_PATTERN: assert property (wr && wb_adr_i == 12'h210
    |=> user_pattern[31:0] == $past(wb_dat_i))
    else $error("pattern word 0 wrong");
  AST_TRIM: assert property (wr && wb_adr_i == 12'h22C
    |=> quad_ctrl[1].tx_termination_trim == $past(wb_dat_i[11:10])
    && quad_ctrl[0].rx_termination_trim == $past(wb_dat_i[17:16]))
    else $error("trim fields wrong");
  AST_EQ: assert property (wr && wb_adr_i == 12'h22C
    |=> quad_ctrl[1].rx_equalizer_select == $past(wb_dat_i[27:26]))
    else $error("equalizer field wrong");
  AST_LOOP_CMD: assert property (wr && wb_adr_i == 12'h230
    |=> loopback_master_allow[1:0] == {$past(wb_dat_i[4]), $past(wb_dat_i[0])})
    else $error("loopback command wrong");
  AST_PRBS_MASTER: assert property (quad_ctrl[0].prbs_run
    && quad_ctrl[0].prbs_loop == quad_analog_master |-> loopback_master_allow[0])
    else $error("master loop without command");
  AST_RESET_ZERO: assert property ($rose(nrst)
    |-> training_control_capture && user_pattern == 128'h0)
    else $error("reset values wrong");
  cover property (wr && wb_adr_i == 12'h230);
  cover property (slave_loopback_request[0]);
  cover property (quad_ctrl[0].prbs_run);
endmodule : phy_test_regs_properties
bind phy_test_regs phy_test_regs_properties u_props (
  .sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .slave_loopback_request(slave_loopback_request),
  .training_control_capture(training_control_capture),
  .slave_loop_mode(slave_loop_mode), .quad_ctrl(quad_ctrl),
  .user_pattern(user_pattern), .loopback_master_allow(loopback_master_allow)
);
`default_nettype wire

// ---- testbench/link_partner.sv ----
// link partner model: training sets, bring-up, loopback master
`default_nettype none
module link_partner
  import phy_test_pkg::*;
(
  input  wire logic [1:0]            ts1_loop,
  input  wire logic                  sys_clk,
  input  wire logic                  nrst,
  input  wire logic                  train_up,
  input  wire logic [port_count-1:0] master_go,
  input  wire logic [port_count-1:0] loopback_master_allow,
  output logic      [port_count-1:0] link_up,
  output logic      [port_count-1:0] config_complete,
  output logic      [port_count-1:0] loopback_master_state,
  output logic      [1:0]            slave_loopback_request
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ts_prev;
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ts_prev <= 2'h0;
      slave_loopback_request <= 2'h0;
      link_up <= 8'h00;
      config_complete <= 8'h00;
      loopback_master_state <= 8'h00;
    end
    else
    begin
      ts_prev <= ts1_loop;
      // one training set alone is no request
      slave_loopback_request <= ts1_loop & ts_prev;
      link_up <= {8{train_up}};
      config_complete <= {8{train_up}};
      loopback_master_state <= master_go & loopback_master_allow;
    end
  end
endmodule : link_partner
`default_nettype wire

// ---- testbench/tb.sv ----
// self-checking testbench for the phy test register bank
`default_nettype none
module tb import phy_test_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic         sys_clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic         eeprom_load_valid, eeprom_load_done, train_up;
  logic         training_control_capture, selftest_running, link_init_enable;
  logic [11:0]  wb_adr_i, eeprom_load_addr;
  logic [3:0]   wb_sel_i;
  logic [31:0]  wb_dat_i, wb_dat_o, q;
  logic [1:0]   slave_loopback_request, ts1_loop, c;
  logic [7:0]   link_up, config_complete, loopback_master_state, master_go;
  logic [7:0]   loopback_master_allow, scrambler_disable, rx_l1_only, b;
  logic [127:0] user_pattern;
  eeprom_load_t eeprom_load;
  slave_loop_t  slave_loop_mode [2];
  quad_ctrl_t   quad_ctrl [2];
  int           err_total, checks_done, cyc_cnt;
  phy_test_regs DUT (.*);
  link_partner  u_partner (.*);
  always #5 sys_clk = ~sys_clk;
  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  always @(posedge sys_clk)
  begin
    cyc_cnt++;
    if (cyc_cnt == 5000)
    begin
      err_total++;
      test_done();
    end
  end
  task automatic chk(string n, logic [127:0] e, logic [127:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // ack and data are read as sampled at the edge, before its updates land
  task automatic wb(logic we, logic [11:0] a, logic [31:0] d);
    @(posedge sys_clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge sys_clk); while (wb_ack_o !== 1'h1);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask : wb
  task automatic rd(logic [11:0] a, logic [31:0] e);
    wb(1'h0, a, 32'h0);
    chk("read data", e, q);
  endtask : rd
  task automatic t_test_reg;
    wb(1'h1, 12'h228, 32'h2011_009C);
    rd(12'h228, 32'h2011_001C);
    chk("capture", 1'h0, training_control_capture);
    chk("pattern run", 1'h0, quad_ctrl[1].user_pattern_run);
    chk("prbs run", 1'h1, quad_ctrl[0].prbs_run);
    wb(1'h1, 12'h230, 32'h0000_0001);
    chk("prbs loop", quad_analog_master, quad_ctrl[0].prbs_loop);
    ts1_loop <= 2'h1;
    repeat (3) @(posedge sys_clk);
    chk("slave mode", loop_analog_slave, slave_loop_mode[0]);
    wb(1'h1, 12'h228, 32'h2011_008C);
    chk("slave mode", loop_digital_slave, slave_loop_mode[0]);
    ts1_loop <= 2'h0;
    repeat (3) @(posedge sys_clk);
    chk("slave mode", loop_none, slave_loop_mode[0]);
  endtask : t_test_reg
  task automatic t_trim;
    for (int i = 0; i < 4; i++)
    begin
      c = 2'(i);
      b = {4'h0, ~c, c};
      wb(1'h1, 12'h22C, {b, b, b, 8'h00});
      rd(12'h22C, {b, b, b, 8'h00});
      chk("tx trim", c, quad_ctrl[0].tx_termination_trim);
      chk("rx trim", b[3:2], quad_ctrl[1].rx_termination_trim);
      chk("rx eq", c, quad_ctrl[0].rx_equalizer_select);
    end
  endtask : t_trim
  task automatic t_pattern;
    for (int n = 0; n < 4; n++)
      wb(1'h1, 12'(12'h210 + 4 * n),
         {8'(4*n+3), 8'(4*n+2), 8'(4*n+1), 8'(4*n)});
    chk("pattern", 128'h0F0E0D0C_0B0A0908_07060504_03020100,
        user_pattern);
    wb(1'h1, 12'h23C, 32'hFFFF_FFFF);
    rd(12'h23C, 32'h0);
  endtask : t_pattern
  task automatic t_eeprom;
    @(posedge sys_clk);
    eeprom_load_valid <= 1'h1;
    eeprom_load_addr <= 12'h228;
    eeprom_load <= '{32'h2011_008C, 4'hF, 1'h1};
    @(posedge sys_clk);
    eeprom_load_addr <= 12'h230;
    eeprom_load <= '{32'h0000_0002, 4'hF, 1'h1};
    @(posedge sys_clk);
    eeprom_load_valid <= 1'h0;
    eeprom_load_done <= 1'h1;
    repeat (2) @(posedge sys_clk);
    chk("self-test run", 1'h1, selftest_running);
    chk("link init", 1'h0, link_init_enable);
    chk("scrambler early", 1'h0, scrambler_disable[0]);
    rd(12'h228, 32'h2011_000C);
    train_up <= 1'h1;
    repeat (3) @(posedge sys_clk);
    chk("scrambler", 1'h1, scrambler_disable[0]);
  endtask : t_eeprom
  task automatic t_port;
    wb(1'h1, 12'h230, 32'hFFFF_FFFF);
    rd(12'h230, 32'h7777_7777);
    chk("allow", 8'hFF, loopback_master_allow);
    chk("scrambler", 8'hFF, scrambler_disable);
    chk("l1 only", 8'hFF, rx_l1_only);
    master_go <= 8'h11;
    repeat (3) @(posedge sys_clk);
    rd(12'h230, 32'h777F_777F);
    chk("pattern run", 1'h1, quad_ctrl[1].user_pattern_run);
    master_go <= 8'h00;
    @(posedge sys_clk);
    rd(12'h230, 32'h7777_7777);
    wb(1'h1, 12'h230, 32'h0);
    chk("allow", 8'h00, loopback_master_allow);
  endtask : t_port
  initial
  begin
    sys_clk = 1'h0;
    nrst = 1'h0;
    {wb_cyc_i, wb_stb_i, wb_we_i, eeprom_load_valid} = 4'h0;
    {eeprom_load_done, train_up, ts1_loop, master_go} = 12'h0;
    {wb_adr_i, eeprom_load_addr, wb_dat_i, eeprom_load} = 93'h0;
    wb_sel_i = 4'hF;
    repeat (16) @(posedge sys_clk);
    nrst <= 1'h1;
    rd(12'h210, 32'h0);
    rd(12'h228, 32'h0);
    rd(12'h22C, 32'h0);
    rd(12'h230, 32'h0);
    chk("capture", 1'h1, training_control_capture);
    t_test_reg();
    t_trim();
    t_pattern();
    t_eeprom();
    t_port();
    test_done();
  end
endmodule : tb
`default_nettype wire
